//--- logic/ssim_consts.vh
// Constants for the switch input monitor
`ifndef SSIM_CONSTS_VH
`define SSIM_CONSTS_VH
// ==========================================
// Widths
`define SSIM_WIDE_CHANNELS   16
`define SSIM_NARROW_CHANNELS 8
// ==========================================
// Reset values
`define SSIM_SYNC_RESET      2'h0
`define SSIM_SYNC_RESET_HIGH 2'h3
`endif

//--- logic/ssim_sync.v
// Two-flop synchroniser for one asynchronous level
`include "ssim_consts.vh"
`default_nettype none
module ssim_sync #(
  parameter [1:0] RESET_VALUE = `SSIM_SYNC_RESET
) (
  input  wire mclk,
  input  wire srst,
  input  wire clk_en,
  input  wire async_in,
  output wire sync_out
);
  reg [1:0] stage;
  always @(posedge mclk) begin
    if (srst) begin
      stage <= RESET_VALUE;
    end else if (clk_en) begin
      stage <= {stage[0], async_in};
    end
  end
  assign sync_out = stage[1];
endmodule // ssim_sync
`default_nettype wire

//--- logic/ssim_edge.v
// Edge finder on a synchronised level
`default_nettype none
module ssim_edge #(
  parameter RESET_VALUE = 1'b0
) (
  input  wire mclk,
  input  wire srst,
  input  wire clk_en,
  input  wire level,
  output wire rise,
  output wire fall
);
  reg last;
  always @(posedge mclk) begin
    if (srst) begin
      last <= RESET_VALUE;
    end else if (clk_en) begin
      last <= level;
    end
  end
  assign rise = clk_en & level & ~last;
  assign fall = clk_en & ~level & last;
endmodule // ssim_edge
`default_nettype wire

//--- logic/ssim_top.v
// Switch input monitor with serial readout and change interrupt
`include "ssim_consts.vh"
`default_nettype none
// Notes on behaviour
// - 16 or 8 inputs, chosen by variant
// - Chip select fall captures inputs into status
// - Chip select fall clears asserted interrupt
// - Serial clock and input ignored while deselected
// - First rising edge loads shift register
// - Later rising edges shift toward output
// - Falling edge samples serial input into sampled, shifted in on next rising edge
// - Serial input ignored while deselected
// - Output released while deselected, driven when selected
// - Output shows MSB first, then descending
// - Interrupt is active low open drain
// - Interrupt low while inputs differ from status
// - Enable low keeps interrupt released
module ssim_top #(
  parameter WIDE = 1
) (
  input  wire                                mclk,
  input  wire                                srst,
  input  wire                                clk_en,
  input  wire [`SSIM_WIDE_CHANNELS-1:0]      switch_input,
  input  wire                                cs_n,
  input  wire                                sclk,
  input  wire                                serial_in,
  input  wire                                int_enable,
  output reg                                 serial_out,
  output reg                                 serial_out_oe_n,
  output reg                                 int_n_out,
  output reg                                 int_n_oe_n
);
  // ==========================================
  // Width of the chosen variant
  localparam N = WIDE ? `SSIM_WIDE_CHANNELS : `SSIM_NARROW_CHANNELS;

  // ==========================================
  // Synchronisers
  wire cs_n_s;
  wire sclk_s;
  wire sin_s;
  wire inten_s;
  wire [`SSIM_WIDE_CHANNELS-1:0] sw_s;

  ssim_sync #(.RESET_VALUE(`SSIM_SYNC_RESET_HIGH)) u_cs (
    .mclk(mclk), .srst(srst), .clk_en(clk_en), .async_in(cs_n), .sync_out(cs_n_s));
  ssim_sync u_sck (
    .mclk(mclk), .srst(srst), .clk_en(clk_en), .async_in(sclk), .sync_out(sclk_s));
  ssim_sync u_sin (
    .mclk(mclk), .srst(srst), .clk_en(clk_en), .async_in(serial_in), .sync_out(sin_s));
  ssim_sync u_ien (
    .mclk(mclk), .srst(srst), .clk_en(clk_en), .async_in(int_enable), .sync_out(inten_s));

  genvar gi;
  generate
    for (gi = 0; gi < `SSIM_WIDE_CHANNELS; gi = gi + 1) begin : g_sw
      ssim_sync u_sw (
        .mclk(mclk), .srst(srst), .clk_en(clk_en), .async_in(switch_input[gi]), .sync_out(sw_s[gi]));
    end
  endgenerate

  // ==========================================
  // Edge detection
  wire cs_fall;
  wire sck_rise;
  wire sck_fall;
  ssim_edge #(.RESET_VALUE(1'b1)) u_cs_edge (
    .mclk(mclk), .srst(srst), .clk_en(clk_en), .level(cs_n_s), .rise(), .fall(cs_fall));
  ssim_edge u_sck_edge (
    .mclk(mclk), .srst(srst), .clk_en(clk_en), .level(sclk_s), .rise(sck_rise), .fall(sck_fall));

  // ==========================================
  // Capture, shift and interrupt state
  reg [N-1:0] status;
  reg [N-1:0] shifter;
  reg         loaded;
  reg         sampled;
  reg         int_clear;
  wire        selected = ~cs_n_s;
  wire [N-1:0] live = sw_s[N-1:0];

  always @(posedge mclk) begin
    if (srst) begin
      status  <= {N{1'b0}};
      shifter <= {N{1'b0}};
      loaded  <= 1'b0;
      sampled <= 1'b0;
    end else if (clk_en) begin
      if (cs_fall) begin
        status <= live;
        loaded <= 1'b0;
      end else if (selected) begin
        if (sck_rise) begin
          if (!loaded) begin
            shifter <= status;
            loaded  <= 1'b1;
          end else begin
            // Sampled input bit sits in the LSB; pass-through for chains
            shifter <= {shifter[N-2:0], sampled};
          end
        end
        if (sck_fall) begin
          sampled <= sin_s;
        end
      end
    end
  end

  // Mismatch re-arms the interrupt only after the compare clears
  wire mismatch = |(live ^ status);

  always @(posedge mclk) begin
    if (srst) begin
      int_clear <= 1'b0;
    end else if (clk_en) begin
      if (cs_fall) begin
        int_clear <= 1'b1;
      end else if (!mismatch) begin
        int_clear <= 1'b0;
      end
    end
  end

  // ==========================================
  // Pin outputs, all registered
  always @(posedge mclk) begin
    if (srst) begin
      serial_out      <= 1'b0;
      serial_out_oe_n <= 1'b1;
      int_n_out       <= 1'b0;
      int_n_oe_n      <= 1'b1;
    end else if (clk_en) begin
      serial_out_oe_n <= ~selected;
      if (selected && sck_rise) begin
        serial_out <= loaded ? shifter[N-2] : status[N-1];
      end
      int_n_out  <= 1'b0;
      int_n_oe_n <= ~(inten_s & mismatch & ~int_clear & ~cs_fall);
    end
  end
endmodule // ssim_top
`default_nettype wire

//--- dv/ssim_top_properties.sv
// Port checker for the switch input monitor
`default_nettype none
module ssim_chk (
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic [15:0] switch_input,
  input wire logic        cs_n,
  input wire logic        sclk,
  input wire logic        int_enable,
  input wire logic        serial_out,
  input wire logic        serial_out_oe_n,
  input wire logic        int_n_out,
  input wire logic        int_n_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Bounds allow two sync flops plus one stage
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  property p_oe_on; $fell(cs_n) |-> ##[1:6] !serial_out_oe_n; endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not driven");
  property p_oe_off; $rose(cs_n) |-> ##[1:6] serial_out_oe_n; endproperty
  a_oe_off: assert property (p_oe_off) else $error("output not released");
  property p_oe_rise; $rose(serial_out_oe_n) |-> cs_n; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("released while selected");
  property p_od; int_n_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("interrupt drives high");
  property p_gate; !int_enable [*4] |=> int_n_oe_n; endproperty
  a_gate: assert property (p_gate) else $error("interrupt while gated");
  property p_clear; $fell(cs_n) ##1 $stable(switch_input) [*8] |-> int_n_oe_n; endproperty
  a_clear: assert property (p_clear) else $error("interrupt not cleared");
  property p_desel; cs_n [*6] |=> $stable(serial_out); endproperty
  a_desel: assert property (p_desel) else $error("output moved while deselected");
  property p_idle; !sclk [*8] |=> $stable(serial_out); endproperty
  a_idle: assert property (p_idle) else $error("output moved without clock");
endmodule // ssim_chk
bind ssim_top ssim_chk ssim_chk_i (.mclk(mclk), .srst(srst), .switch_input(switch_input), .cs_n(cs_n),
  .sclk(sclk), .int_enable(int_enable), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
  .int_n_out(int_n_out), .int_n_oe_n(int_n_oe_n));
`default_nettype wire

//--- dv/ssim_ctrl.sv
// Serial controller model, last device of a chain
`default_nettype none
module ssim_ctrl (
  input  wire logic mclk,
  input  wire logic serial_out,
  output var  logic cs_n = 1'b1,
  output var  logic sclk = 1'b0,
  output var  logic serial_in = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Data line churns while deselected
  always @(posedge mclk) if (cs_n) serial_in <= ~serial_in;
  task automatic noise();
    repeat (8) begin
      sclk <= ~sclk;
      repeat (4) @(posedge mclk);
    end
  endtask
  task automatic xfer(input logic [7:0] din, output logic [23:0] dout);
    cs_n <= 1'b0;
    repeat (5) @(posedge mclk);
    for (int k = 0; k < 24; k++) begin
      sclk <= 1'b1;
      serial_in <= din[7 - k % 8];
      repeat (4) @(posedge mclk);
      sclk <= 1'b0;
      repeat (4) @(posedge mclk);
      dout = {dout[22:0], serial_out};
    end
    cs_n <= 1'b1;
    @(posedge mclk);
  endtask
endmodule // ssim_ctrl
`default_nettype wire

//--- dv/ssim_top_test.sv
// Self-checking bench for the switch input monitor
`default_nettype none
module ssim_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, srst = 1'b1, int_enable = 1'b1;
  logic [15:0] switch_input = 16'h0000, sw0;
  logic serial_out, serial_out_oe_n, int_n_out, int_n_oe_n, cs_n, sclk, serial_in;
  logic [23:0] dout;
  logic [7:0] din;
  int n_mismatch = 0, tests_run = 0, cycles = 0, seed = 32'h4db71b3e;
  wire sdo = serial_out_oe_n ? 1'bz : serial_out;
  wire int_line = int_n_oe_n ? 1'b1 : int_n_out;
  always #10 mclk = ~mclk;
  ssim_top #(.WIDE(1)) ssim_top_i (.mclk(mclk), .srst(srst), .clk_en(1'b1), .switch_input(switch_input),
    .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in), .int_enable(int_enable), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .int_n_out(int_n_out), .int_n_oe_n(int_n_oe_n));
  ssim_ctrl ssim_ctrl_i (.mclk(mclk), .serial_out(sdo), .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in));
  function automatic logic [23:0] exp_read(input logic [15:0] sw, input logic [7:0] d);
    return {sw, d};
  endfunction
  function automatic logic exp_int(input logic en, input logic differ);
    return !(en && differ);
  endfunction
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // Hang guard, about four times the run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 12000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      sw0 = (i == 1) ? 16'hffff : 16'($random(seed));
      din = 8'($random(seed));
      switch_input <= sw0;
      ssim_ctrl_i.noise();
      ssim_ctrl_i.xfer(din, dout);
      check("readout", exp_read(sw0, din), dout);
      repeat (6) @(posedge mclk);
      check("released output", 24'h0, {23'h0, sdo !== 1'bz});
      int_enable <= i[0];
      switch_input <= sw0 ^ (16'h0001 << i);
      repeat (8) @(posedge mclk);
      check("interrupt", {23'h0, exp_int(i[0], 1'b1)}, {23'h0, int_line});
      if (i[1]) ssim_ctrl_i.xfer(din, dout);
      else switch_input <= sw0;
      repeat (8) @(posedge mclk);
      check("interrupt idle", 24'h1, {23'h0, int_line});
    end
    end_of_test();
  end
endmodule // ssim_top_test
`default_nettype wire
